// File: src/gcp_consts.svh
// Constants for the pin-control command interpreter
`ifndef GCP_CONSTS_SVH
`define GCP_CONSTS_SVH
`define GCP_FRAME_BYTES   4'd9
`define GCP_RESP_BYTES    3'd5
`define GCP_NPINS         3
`define GCP_CMD_GET_FUNC  8'h10
`define GCP_CMD_GET_DIR   8'h11
`define GCP_CMD_GET_LVL   8'h12
`define GCP_CMD_GET_STATE 8'h13
`define GCP_CMD_SET_DIR   8'h19
`define GCP_CMD_SET_LVL   8'h1a
`define GCP_CMD_SET_STATE 8'h1b
`define GCP_ERR_BYTE      8'hff
`define GCP_RST_DIR       3'h0
`define GCP_RST_LVL       3'h7
`define GCP_RST_STATE     3'h0
`endif

// File: src/gcp_interp.sv
// Pin-control command interpreter with per-pin vectors and pin drivers
// Function
// (RULE1) Command frame is nine bytes exactly
// (RULE2) Parameters little-endian, pin 0 bit 0
// (RULE3) Non-GPIO pin bits undefined, updates ignored
// (RULE4) Valid command answers echo plus four bytes
// (RULE5) Unknown command answers single 0FFh byte
// (RULE6) Host awaits response before next command
// (RULE7) UDP command sits in one datagram
// (RULE8) Codes 10h-13h read the four vectors
// (RULE9) Codes 19h-1Bh masked update, return vector
// (RULE10) No command changes the function vector
// (RULE11) Updates live only in volatile flops
// (RULE12) Function bit one means general purpose
// (RULE13) Direction one is output, zero input
// (RULE14) Level one means active low
// (RULE15) State one means pin active
// (RULE16) Reset: general-purpose input, active low
// (RULE17) Vectors 32 bits, upper bits ignored
// (RULE18) TCP and UDP accepted; disable setting
// (RULE19) Enabled by default; disabled refuses commands
// (RULE20) Collect nine bytes before executing
`timescale 1ns/100ps
`default_nettype none
`include "gcp_consts.svh"
module gcp_interp (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire gcp_pkg::gcp_byte_t rx_byte,
  output logic                   rx_ready,
  input  wire logic              port_disable,
  input  wire logic [2:0]        pin_func,
  output gcp_pkg::gcp_byte_t     tx_byte,
  input  wire logic              tx_ready,
  output logic                   cmd_refused,
  input  wire logic [2:0]        pin_in,
  output logic [2:0]             pin_out,
  output logic [2:0]             pin_oe
);
  import gcp_pkg::*;

  gcp_state_t  state_ff;
  gcp_state_t  nxt_state;
  logic [7:0]  frame_ff [0:8];
  logic [3:0]  cnt_ff;
  logic [2:0]  dir_ff;
  logic [2:0]  lvl_ff;
  logic [2:0]  st_ff;
  logic [7:0]  resp_ff [0:4];
  logic [2:0]  rlen_ff;
  logic [2:0]  ridx_ff;
  gcp_byte_t   tx_ff;
  logic        refused_ff;
  logic        rx_ready_ff;
  logic [2:0]  pin_out_ff;
  logic [2:0]  pin_oe_ff;
  logic [2:0]  in_s1_ff;
  logic [2:0]  in_s2_ff;
  logic [2:0]  in_s3_ff;
  logic [2:0]  in_ok_ff;

  function automatic logic [2:0] masked(input logic [2:0] cur, input logic [2:0] msk,
                                        input logic [2:0] val, input logic [2:0] gp);
    masked = (cur & ~(msk & gp)) | (val & msk & gp); // RULE3
  endfunction

  function automatic logic [31:0] word_at(input logic [7:0] b0, input logic [7:0] b1,
                                          input logic [7:0] b2, input logic [7:0] b3);
    word_at = {b3, b2, b1, b0};
  endfunction

  wire         rx_take    = rx_byte.valid && rx_ready;
  wire  [7:0]  cmd_byte   = frame_ff[0];
  wire  [31:0] mask_word  = word_at(frame_ff[1], frame_ff[2], frame_ff[3], frame_ff[4]); // RULE2
  wire  [31:0] val_word   = word_at(frame_ff[5], frame_ff[6], frame_ff[7], frame_ff[8]); // RULE2
  wire  [2:0]  msk3       = mask_word[2:0]; // RULE17
  wire  [2:0]  val3       = val_word[2:0]; // RULE17
  wire  [2:0]  gp_mask    = pin_func; // RULE12
  wire         is_get     = cmd_byte inside {`GCP_CMD_GET_FUNC, `GCP_CMD_GET_DIR,
                                             `GCP_CMD_GET_LVL, `GCP_CMD_GET_STATE};
  wire         is_set     = cmd_byte inside {`GCP_CMD_SET_DIR, `GCP_CMD_SET_LVL, `GCP_CMD_SET_STATE};
  wire  [2:0]  new_dir    = (cmd_byte == `GCP_CMD_SET_DIR) ? masked(dir_ff, msk3, val3, gp_mask) : dir_ff; // RULE9
  wire  [2:0]  new_lvl    = (cmd_byte == `GCP_CMD_SET_LVL) ? masked(lvl_ff, msk3, val3, gp_mask) : lvl_ff; // RULE9
  wire  [2:0]  new_st     = (cmd_byte == `GCP_CMD_SET_STATE) ? masked(st_ff, msk3, val3, gp_mask) : st_ff; // RULE9
  wire  [2:0]  in_state   = in_ok_ff ^ lvl_ff; // RULE15
  wire  [2:0]  in_agree   = ~(in_s2_ff ^ in_s3_ff);
  wire  [2:0]  cur_state  = (dir_ff & st_ff) | (~dir_ff & in_state);
  logic [2:0]  vec3;
  // RULE3: non-GPIO bits read as zero; RULE17: upper bits zero
  always_comb begin
    unique case (cmd_byte)
      `GCP_CMD_GET_FUNC:                     vec3 = pin_func; // RULE8
      `GCP_CMD_GET_DIR, `GCP_CMD_SET_DIR:    vec3 = new_dir & gp_mask; // RULE8 RULE3
      `GCP_CMD_GET_LVL, `GCP_CMD_SET_LVL:    vec3 = new_lvl & gp_mask; // RULE8
      `GCP_CMD_GET_STATE:                    vec3 = cur_state & gp_mask; // RULE8
      `GCP_CMD_SET_STATE:                    vec3 = new_st & gp_mask;
      default:                               vec3 = 3'h0;
    endcase
  end
  wire         last_byte  = (cnt_ff == `GCP_FRAME_BYTES - 4'd1);
  wire         reply_done = tx_ff.valid && tx_ready && tx_ff.last;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      GCP_ST_COLLECT: if (rx_take && last_byte && !port_disable) nxt_state = GCP_ST_EXEC; // RULE20
      GCP_ST_EXEC:    nxt_state = GCP_ST_REPLY;
      GCP_ST_REPLY:   if (reply_done) nxt_state = GCP_ST_COLLECT;
      default:        nxt_state = GCP_ST_COLLECT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) rx_ready_ff <= 1'b1;
    else      rx_ready_ff <= (nxt_state == GCP_ST_COLLECT); // RULE6
  end
  assign rx_ready = rx_ready_ff;

  property p_ready_state;
    @(posedge ref_clk) disable iff (srst)
    rx_ready == (state_ff == GCP_ST_COLLECT);
  endproperty
  a_ready_state: assert property (p_ready_state) else $error("byte ready out of step with state"); // RULE20

  always_ff @(posedge ref_clk) begin
    if (srst) state_ff <= GCP_ST_COLLECT;
    else      state_ff <= nxt_state;
  end

  // Frame collection; a frame ends at nine bytes or at a datagram end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_ff <= 4'h0;
    end else if (rx_take) begin
      if (last_byte || rx_byte.last) cnt_ff <= 4'h0; // RULE1 RULE7
      else                           cnt_ff <= cnt_ff + 4'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rx_take) frame_ff[cnt_ff] <= rx_byte.data;
  end

  // Volatile vectors; nothing can write the function vector
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dir_ff <= `GCP_RST_DIR; // RULE16
      lvl_ff <= `GCP_RST_LVL; // RULE16
      st_ff  <= `GCP_RST_STATE;
    end else if (state_ff == GCP_ST_EXEC) begin // RULE10 RULE11
      dir_ff <= new_dir;
      lvl_ff <= new_lvl;
      st_ff  <= new_st;
    end
  end

  property p_set_copy;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && cmd_byte == `GCP_CMD_SET_DIR) |=>
      (((dir_ff ^ $past(val3)) & $past(msk3 & gp_mask)) == 3'h0);
  endproperty
  a_set_copy: assert property (p_set_copy) else $error("masked direction bit not copied"); // RULE9

  property p_set_keep;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && cmd_byte == `GCP_CMD_SET_LVL) |=>
      (((lvl_ff ^ $past(lvl_ff)) & ~$past(msk3 & gp_mask)) == 3'h0);
  endproperty
  a_set_keep: assert property (p_set_keep) else $error("unmasked or non-general level changed"); // RULE3

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rlen_ff <= 3'h0;
    end else if (state_ff == GCP_ST_EXEC) begin
      if (is_get || is_set) begin
        resp_ff[0] <= cmd_byte; // RULE4
        resp_ff[1] <= {5'h0, vec3}; // RULE2 RULE17
        resp_ff[2] <= 8'h00;
        resp_ff[3] <= 8'h00;
        resp_ff[4] <= 8'h00;
        rlen_ff    <= `GCP_RESP_BYTES; // RULE4
      end else begin
        resp_ff[0] <= `GCP_ERR_BYTE; // RULE5
        rlen_ff    <= 3'd1; // RULE5
      end
    end
  end

  property p_func_read;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && cmd_byte == `GCP_CMD_GET_FUNC) |=> (resp_ff[1] == {5'h0, $past(pin_func)});
  endproperty
  a_func_read: assert property (p_func_read) else $error("function vector read wrong"); // RULE12

  // Transmit sequencer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_ff   <= '0;
      ridx_ff <= 3'h0;
    end else if (state_ff == GCP_ST_EXEC) begin
      tx_ff.valid <= 1'b0;
      ridx_ff     <= 3'h0;
    end else if (state_ff == GCP_ST_REPLY) begin
      if (!tx_ff.valid || tx_ready) begin
        if (tx_ff.valid && tx_ff.last) begin
          tx_ff.valid <= 1'b0;
        end else begin
          tx_ff.valid <= 1'b1;
          tx_ff.data  <= resp_ff[ridx_ff];
          tx_ff.last  <= (ridx_ff == rlen_ff - 3'd1);
          ridx_ff     <= ridx_ff + 3'd1;
        end
      end
    end else begin
      tx_ff.valid <= 1'b0;
    end
  end
  assign tx_byte = tx_ff;

  property p_tx_hold;
    @(posedge ref_clk) disable iff (srst)
    (tx_byte.valid && !tx_ready) |=> (tx_byte.valid && $stable(tx_byte.data) && $stable(tx_byte.last));
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held until taken"); // RULE4

  property p_first_byte;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC) |-> ##2 (tx_byte.valid && tx_byte.data == resp_ff[0]);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply did not start with first byte"); // RULE4

  always_ff @(posedge ref_clk) begin
    if (srst) refused_ff <= 1'b0;
    else      refused_ff <= rx_take && last_byte && port_disable; // RULE18 RULE19
  end
  assign cmd_refused = refused_ff;

  property p_refuse_quiet;
    @(posedge ref_clk) disable iff (srst)
    cmd_refused |-> (state_ff == GCP_ST_COLLECT && !tx_byte.valid);
  endproperty
  a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused frame produced a reply"); // RULE19

  // Input synchroniser, change accepted when stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      in_s1_ff <= 3'h0;
      in_s2_ff <= 3'h0;
      in_s3_ff <= 3'h0;
      in_ok_ff <= 3'h0;
    end else begin
      in_s1_ff <= pin_in;
      in_s2_ff <= in_s1_ff;
      in_s3_ff <= in_s2_ff;
      in_ok_ff <= (in_s2_ff & in_agree) | (in_ok_ff & ~in_agree);
    end
  end

  property p_in_follow;
    @(posedge ref_clk) disable iff (srst)
    (in_s2_ff == in_s3_ff) |=> (in_ok_ff == $past(in_s2_ff));
  endproperty
  a_in_follow: assert property (p_in_follow) else $error("settled input not taken"); // RULE15

  // Pin drivers; only general-purpose outputs drive
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_out_ff <= 3'h0;
      pin_oe_ff  <= 3'h0;
    end else begin
      pin_out_ff <= st_ff ^ lvl_ff; // RULE14 RULE15
      pin_oe_ff  <= dir_ff & gp_mask; // RULE13 RULE12
    end
  end
  assign pin_out = pin_out_ff;
  assign pin_oe  = pin_oe_ff;

  property p_oe_func;
    @(posedge ref_clk) disable iff (srst)
    !srst |=> ((pin_oe & ~$past(pin_func)) == 3'h0);
  endproperty
  a_oe_func: assert property (p_oe_func) else $error("dedicated pin driven"); // RULE12

  property p_reset_vec;
    @(posedge ref_clk)
    srst |=> (dir_ff == `GCP_RST_DIR && lvl_ff == `GCP_RST_LVL && !tx_byte.valid && pin_oe == 3'h0);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset defaults wrong"); // RULE16

  // Checks
  property p_reply_len;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && (is_get || is_set)) |=> (rlen_ff == 3'd5);
  endproperty
  a_reply_len: assert property (p_reply_len) else $error("valid reply not five bytes"); // RULE4

  property p_err_byte;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && !is_get && !is_set) |=> (resp_ff[0] == 8'hff && rlen_ff == 3'd1);
  endproperty
  a_err_byte: assert property (p_err_byte) else $error("unknown command not answered with ff"); // RULE5

  property p_echo;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && (is_get || is_set)) |=> (resp_ff[0] == $past(cmd_byte));
  endproperty
  a_echo: assert property (p_echo) else $error("command byte not echoed"); // RULE4

  property p_get_keeps;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && is_get) |=> ($stable(dir_ff) && $stable(lvl_ff) && $stable(st_ff));
  endproperty
  a_get_keeps: assert property (p_get_keeps) else $error("read command altered a vector"); // RULE8

  property p_mask_zero;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_EXEC && cmd_byte == `GCP_CMD_SET_STATE && msk3 == 3'h0) |=> $stable(st_ff);
  endproperty
  a_mask_zero: assert property (p_mask_zero) else $error("masked-out state changed"); // RULE9

  property p_disabled;
    @(posedge ref_clk) disable iff (srst)
    (port_disable && rx_take && last_byte) |=> (state_ff == GCP_ST_COLLECT) ##1 !tx_byte.valid;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled port executed a command"); // RULE19

  property p_refused;
    @(posedge ref_clk) disable iff (srst)
    (port_disable && rx_take && last_byte) |=> (cmd_refused && state_ff == GCP_ST_COLLECT);
  endproperty
  a_refused: assert property (p_refused) else $error("refusal not flagged"); // RULE18

  property p_exec_after_nine;
    @(posedge ref_clk) disable iff (srst)
    (state_ff == GCP_ST_COLLECT && nxt_state == GCP_ST_EXEC) |-> (cnt_ff == 4'd8);
  endproperty
  a_exec_after_nine: assert property (p_exec_after_nine) else $error("executed before nine bytes"); // RULE20

  property p_pin_level;
    @(posedge ref_clk) disable iff (srst)
    !srst |=> (pin_out == $past(st_ff ^ lvl_ff));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level wrong for active setting"); // RULE14

  property p_no_drive_input;
    @(posedge ref_clk) disable iff (srst)
    !srst |=> ((pin_oe & ~$past(dir_ff)) == 3'h0);
  endproperty
  a_no_drive_input: assert property (p_no_drive_input) else $error("input pin driven"); // RULE13
endmodule // gcp_interp
`default_nettype wire

// File: src/gcp_pkg.sv
// Types for the pin-control command interpreter
package gcp_pkg;
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } gcp_byte_t;
  typedef enum logic [1:0] {
    GCP_ST_COLLECT = 2'b00,
    GCP_ST_EXEC    = 2'b01,
    GCP_ST_REPLY   = 2'b11
  } gcp_state_t;
endpackage

// File: test/gcp_host.sv
// Host model that sends command frames and collects replies
`timescale 1ns/100ps
`default_nettype none
module gcp_host (
  input  wire logic               ref_clk,
  output var gcp_pkg::gcp_byte_t  rx_byte,
  input  wire logic               rx_ready,
  input  wire gcp_pkg::gcp_byte_t tx_byte,
  output logic                    tx_ready
);
  import gcp_pkg::*;
  logic slow = 1'b0;
  initial begin
    rx_byte = '0;
    tx_ready = 1'b0;
  end
  // Each byte held until taken; idle data scrambled
  task automatic send(input logic [71:0] f, input int n, input logic u);
    for (int i = 0; i < n; i++) begin
      rx_byte <= {1'b1, u && i == n - 1, f[8*i+:8]};
      do @(posedge ref_clk); while (!rx_ready);
    end
    rx_byte <= {2'b00, ~rx_byte.data};
  endtask
  // Stalls on alternate cycles when slow
  task automatic recv(input int n, output logic [39:0] r, output logic lst);
    int k;
    int t;
    r = '0;
    lst = 1'b0;
    k = 0;
    t = 0;
    while (k < n && t < 100) begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      @(posedge ref_clk);
      t++;
      if (tx_byte.valid === 1'b1 && tx_ready === 1'b1) begin
        r[8*k+:8] = tx_byte.data;
        lst = tx_byte.last;
        k++;
      end
    end
    if (k < n) lst = 1'b0;
    tx_ready <= 1'b0;
  endtask
endmodule // gcp_host
`default_nettype wire

// File: test/test_gcp_interp.sv
// Self-checking bench for the pin-control command interpreter
`timescale 1ns/100ps
`default_nettype none
module test_gcp_interp;
  import gcp_pkg::*;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       port_disable = 1'b0;
  logic [2:0] pin_func = 3'h7;
  logic [2:0] pin_in = 3'h0;
  gcp_byte_t  rx_byte;
  gcp_byte_t  tx_byte;
  logic       rx_ready;
  logic       tx_ready;
  logic       cmd_refused;
  logic [2:0] pin_out;
  logic [2:0] pin_oe;
  int         failures = 0;
  int         compares = 0;
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  gcp_interp u_dut (.ref_clk(ref_clk), .srst(srst), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .port_disable(port_disable), .pin_func(pin_func), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .cmd_refused(cmd_refused), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  gcp_host u_host (.ref_clk(ref_clk), .rx_byte(rx_byte), .rx_ready(rx_ready), .tx_byte(tx_byte),
    .tx_ready(tx_ready));
  task automatic close_out();
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] m, input logic [31:0] v, input int n,
                     input logic [39:0] e, input logic u);
    logic [39:0] r;
    logic lst;
    u_host.send({v, m, c}, 9, u);
    u_host.recv(n, r, lst);
    chk(r, e);
    @(posedge ref_clk);
    chk({38'h0, lst, tx_byte.valid}, 40'h2);
  endtask
  task automatic t_reset();
    cmd(8'h11, '1, '1, 5, {32'h0, 8'h11}, 1'b0);
    cmd(8'h12, 0, 0, 5, {32'h7, 8'h12}, 1'b1);
    chk({37'h0, pin_oe}, 40'h0);
  endtask
  task automatic t_bad();
    logic [7:0] codes[5] = '{8'h00, 8'h14, 8'h18, 8'h1c, 8'hff};
    pin_func <= 3'b011;
    foreach (codes[i]) cmd(codes[i], '1, '1, 1, {32'h0, 8'hff}, i[0]);
    cmd(8'h10, '1, 0, 5, {32'h3, 8'h10}, 1'b0);
  endtask
  task automatic t_set();
    cmd(8'h19, '1, '1, 5, {32'h3, 8'h19}, 1'b1);
    cmd(8'h1a, 1, 0, 5, {32'h2, 8'h1a}, 1'b0);
    cmd(8'h1b, 3, 3, 5, {32'h3, 8'h1b}, 1'b0);
    cmd(8'h1b, 0, 0, 5, {32'h3, 8'h1b}, 1'b1);
    chk({35'h0, pin_oe, pin_out[1:0]}, 40'h0d);
  endtask
  task automatic t_off();
    int seen;
    seen = 0;
    port_disable <= 1'b1;
    u_host.send({32'h0, 32'h3, 8'h1b}, 9, 1'b0);
    repeat (6) begin
      @(posedge ref_clk);
      seen += (cmd_refused === 1'b1) + 10 * (tx_byte.valid !== 1'b0);
    end
    chk(40'(seen), 40'd1);
    port_disable <= 1'b0;
    cmd(8'h1b, 0, 0, 5, {32'h3, 8'h1b}, 1'b0);
  endtask
  task automatic t_input();
    u_host.send({32'h0, 32'h0, 8'h19}, 4, 1'b1);
    @(posedge ref_clk);
    cmd(8'h19, 3, 0, 5, {32'h0, 8'h19}, 1'b1);
    pin_in <= 3'b001;
    repeat (6) @(posedge ref_clk);
    u_host.slow = 1'b1;
    cmd(8'h13, 0, 0, 5, {32'h3, 8'h13}, 1'b0);
    pin_in <= 3'b000;
    repeat (6) @(posedge ref_clk);
    cmd(8'h13, 0, 0, 5, {32'h2, 8'h13}, 1'b1);
    u_host.slow = 1'b0;
    chk({37'h0, pin_oe}, 40'h0);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_bad();
    t_set();
    t_off();
    t_input();
    pin_func <= 3'h7;
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    close_out();
  end
  initial begin
    #50000;
    failures++;
    close_out();
  end
endmodule // test_gcp_interp
`default_nettype wire
